// >>> verilog/ecd_pkg.sv
/*
 * Package for the echo canceller duplex configuration block: register
 * offsets, field positions, reset values, encodings and bus carriers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package ecd_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] ECD_OFS_THR_GAIN = 8'h00;
   localparam logic [7:0] ECD_OFS_DIAG = 8'h04;
   localparam logic [7:0] ECD_OFS_ESTIM = 8'h08;
   localparam logic [7:0] ECD_OFS_STATUS = 8'h0C;
   localparam logic [7:0] ECD_OFS_ID = 8'h10;

   // identity value is arbitrary
   localparam logic [15:0] ECD_ID_VALUE = 16'h5A01;

   // ************************************************************
   // word tags in the low nibble and reset values
   // ************************************************************
   localparam logic [3:0] ECD_TAG_THR_GAIN = 4'h8;
   localparam logic [3:0] ECD_TAG_DIAG = 4'hA;
   localparam logic [15:0] ECD_RST_THR_GAIN = 16'h0008;
   localparam logic [15:0] ECD_RST_DIAG = 16'h000A;

   // ************************************************************
   // field positions, threshold and gain word
   // ************************************************************
   localparam int ECD_AEC_DEPTH_LSB = 14;
   localparam int ECD_AEC_NOISE_LSB = 12;
   localparam int ECD_NEC_DEPTH_LSB = 10;
   localparam int ECD_NEC_NOISE_LSB = 8;
   localparam int ECD_RX_GAIN_LSB = 6;
   localparam int ECD_TX_GAIN_LSB = 4;

   // ************************************************************
   // field positions, diagnostic word
   // ************************************************************
   localparam int ECD_HOWL_OFF_BIT = 15;
   localparam int ECD_TONE_OFF_BIT = 14;
   localparam int ECD_APC_OFF_BIT = 13;
   localparam int ECD_NPC_OFF_BIT = 12;
   localparam int ECD_APF_OFF_BIT = 11;
   localparam int ECD_NPF_OFF_BIT = 10;
   localparam int ECD_AEC_OFF_BIT = 9;
   localparam int ECD_NEC_OFF_BIT = 8;
   localparam int ECD_ACOUSTIC_SIDETONE_LEVEL_LSB = 6;
   localparam int ECD_NETWORK_SIDETONE_LEVEL_LSB = 4;

   // ************************************************************
   // depth codes in 6 dB steps of erle: 00 24, 01 18, 10 30 dB
   // noise codes in dB below full scale: 01 -42, 10 -54, 00 zero
   // ************************************************************
   localparam logic [7:0] ECD_DB_18 = 8'h12;
   localparam logic [7:0] ECD_DB_24 = 8'h18;
   localparam logic [7:0] ECD_DB_30 = 8'h1E;
   localparam logic [7:0] ECD_DB_42 = 8'h2A;
   localparam logic [7:0] ECD_DB_54 = 8'h36;
   localparam logic [1:0] ECD_CODE_RSVD = 2'h3;
   localparam logic [1:0] ECD_CODE_ZERO = 2'h0;

   typedef enum logic [1:0] {
      ECD_DUP_HALF_IDLE = 2'b00,
      ECD_DUP_HALF_RX = 2'b01,
      ECD_DUP_FULL = 2'b10
   } ecd_duplex_e;

   localparam logic [1:0] ECD_RESP_OKAY = 2'h0;
   localparam logic [1:0] ECD_RESP_SLVERR = 2'h2;

   // per-canceller estimator inputs, in dB magnitudes
   typedef struct packed {
      logic [7:0] erle_db;
      logic [7:0] noise_db;
      logic [7:0] asym_db;
      logic path_present;
   } ecd_canc_meas_s;

   // datapath controls issued to the signal engine
   typedef struct packed {
      logic aec_in_path;
      logic nec_in_path;
      logic aec_clear;
      logic nec_clear;
      logic aec_freeze;
      logic apc_enable;
      logic npc_enable;
      logic apf_enable;
      logic npf_enable;
      logic [1:0] rx_gain;
      logic [1:0] tx_gain;
      logic [1:0] acoustic_sidetone_level;
      logic [1:0] network_sidetone_level;
   } ecd_ctrl_s;
endpackage

// >>> verilog/ecd_config.sv
/*
 * Echo canceller duplex configuration: two 16-bit control words behind an
 * AXI4-Lite slave, plus the full-duplex gating, howl and tone responses
 * that those words steer.
 * Assumes measurements and event strobes arrive on clk_sys from the engine.
 */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps

module ecd_config
   import ecd_pkg::*;
#(
   parameter int FREEZE_CYCLES = 64
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ecd_canc_meas_s aec_meas,
   input wire ecd_canc_meas_s nec_meas,
   input wire logic howl_event,
   input wire logic tone_event,
   output ecd_ctrl_s ctrl,
   output ecd_duplex_e duplex_state
);

   // ************************************************************
   // register storage
   // ************************************************************
   logic [15:0] thr_gain_reg;
   logic [15:0] diag_reg;
   logic [31:0] estim_reg;
   logic [7:0] freeze_cnt_reg;
   logic [7:0] status_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // ************************************************************
   // field decode
   // ************************************************************
   function automatic logic [7:0] depth_db(input logic [1:0] code);
      case (code)
         2'h1: depth_db = ECD_DB_18;
         2'h2: depth_db = ECD_DB_30;
         default: depth_db = ECD_DB_24;
      endcase
   endfunction

   function automatic logic [7:0] noise_db(input logic [1:0] code);
      case (code)
         2'h1: noise_db = ECD_DB_42;
         2'h2: noise_db = ECD_DB_54;
         default: noise_db = 8'h00;
      endcase
   endfunction

   // full duplex permission for one canceller; noise is a magnitude below
   // full scale, so a smaller figure means a louder input
   function automatic logic fd_allow(input ecd_canc_meas_s m, input logic [1:0] dcode,
                                     input logic [1:0] ncode);
      logic noisy;
      noisy = (ncode == ECD_CODE_ZERO) || (m.noise_db < noise_db(ncode));
      if (noisy) begin
         fd_allow = m.erle_db >= depth_db(dcode);
      end else begin
         fd_allow = m.asym_db >= depth_db(dcode);
      end
   endfunction

   logic [1:0] aec_dcode;
   logic [1:0] aec_ncode;
   logic [1:0] nec_dcode;
   logic [1:0] nec_ncode;
   logic aec_on;
   logic nec_on;
   logic aec_ok;
   logic nec_ok;
   logic fd_ok;
   logic howl_act;
   logic tone_act;

   assign aec_dcode = thr_gain_reg[ECD_AEC_DEPTH_LSB +: 2];
   assign aec_ncode = thr_gain_reg[ECD_AEC_NOISE_LSB +: 2];
   assign nec_dcode = thr_gain_reg[ECD_NEC_DEPTH_LSB +: 2];
   assign nec_ncode = thr_gain_reg[ECD_NEC_NOISE_LSB +: 2];

   assign aec_on = !diag_reg[ECD_AEC_OFF_BIT];
   assign nec_on = !diag_reg[ECD_NEC_OFF_BIT] && ((nec_ncode == ECD_CODE_ZERO) || nec_meas.path_present);

   // ************************************************************
   // per-canceller full duplex test: index 0 acoustic, 1 network
   // ************************************************************
   ecd_canc_meas_s canc_meas [2];
   logic [1:0] canc_dcode [2];
   logic [1:0] canc_ncode [2];
   logic [1:0] canc_ok;

   assign canc_meas[0] = aec_meas;
   assign canc_meas[1] = nec_meas;
   assign canc_dcode[0] = aec_dcode;
   assign canc_dcode[1] = nec_dcode;
   assign canc_ncode[0] = aec_ncode;
   assign canc_ncode[1] = nec_ncode;

   for (genvar c = 0; c < 2; c++) begin : g_canc
      assign canc_ok[c] = fd_allow(canc_meas[c], canc_dcode[c], canc_ncode[c]);
   end

   assign aec_ok = canc_ok[0];
   assign nec_ok = canc_ok[1];

   // ************************************************************
   // duplex permission
   // ************************************************************
   assign fd_ok = (!aec_on || aec_ok) && (!nec_on || nec_ok) && (aec_on || nec_on);

   // ************************************************************
   // event qualification
   // ************************************************************
   assign howl_act = howl_event && !diag_reg[ECD_HOWL_OFF_BIT];
   assign tone_act = tone_event && !diag_reg[ECD_TONE_OFF_BIT];

   // ************************************************************
   // write channel: address and data taken in either order
   // ************************************************************
   logic wr_fire;
   logic wr_ok;
   logic [15:0] wr_word;
   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign wr_word = wdata_reg[15:0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_hold_reg <= 1'b0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         w_hold_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_hold_reg <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_hold_reg && !s_axi_wready;
      end
   end

   // a word counts only with both low byte lanes and the right tag
   always_comb begin
      wr_ok = 1'b0;
      if (wstrb_reg[1:0] == 2'h3) begin
         case (awaddr_reg)
            ECD_OFS_THR_GAIN: wr_ok = wr_word[3:0] == ECD_TAG_THR_GAIN;
            ECD_OFS_DIAG: wr_ok = wr_word[3:0] == ECD_TAG_DIAG;
            default: wr_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ECD_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? ECD_RESP_OKAY : ECD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // control words
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         thr_gain_reg <= ECD_RST_THR_GAIN;
      end else if (wr_fire && wr_ok && awaddr_reg == ECD_OFS_THR_GAIN) begin
         thr_gain_reg <= wr_word;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         diag_reg <= ECD_RST_DIAG;
      end else if (wr_fire && wr_ok && awaddr_reg == ECD_OFS_DIAG) begin
         diag_reg <= wr_word;
      end
   end

   // ************************************************************
   // duplex engine
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         duplex_state <= ECD_DUP_HALF_IDLE;
      end else if (howl_act) begin
         duplex_state <= ECD_DUP_HALF_IDLE;
      end else begin
         case (duplex_state)
            ECD_DUP_FULL: begin
               if (!fd_ok) begin
                  duplex_state <= ECD_DUP_HALF_IDLE;
               end
            end
            ECD_DUP_HALF_IDLE, ECD_DUP_HALF_RX: begin
               if (tone_act) begin
                  duplex_state <= ECD_DUP_HALF_RX;
               end else if (fd_ok) begin
                  duplex_state <= ECD_DUP_FULL;
               end else begin
                  duplex_state <= ECD_DUP_HALF_IDLE;
               end
            end
            default: duplex_state <= ECD_DUP_HALF_IDLE;
         endcase
      end
   end

   // tone freeze window while in full duplex
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         freeze_cnt_reg <= 8'h00;
      end else if (tone_act && duplex_state == ECD_DUP_FULL) begin
         freeze_cnt_reg <= 8'(FREEZE_CYCLES);
      end else if (freeze_cnt_reg != 8'h00) begin
         freeze_cnt_reg <= freeze_cnt_reg - 8'h01;
      end
   end

   // ************************************************************
   // control outputs
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl <= '0;
      end else begin
         ctrl.aec_in_path <= aec_on;
         ctrl.nec_in_path <= nec_on;
         ctrl.aec_clear <= howl_act || (tone_act && duplex_state != ECD_DUP_FULL);
         ctrl.nec_clear <= howl_act;
         ctrl.aec_freeze <= (tone_act && duplex_state == ECD_DUP_FULL) || freeze_cnt_reg != 8'h00;
         ctrl.apc_enable <= !diag_reg[ECD_APC_OFF_BIT];
         ctrl.npc_enable <= !diag_reg[ECD_NPC_OFF_BIT];
         ctrl.apf_enable <= !diag_reg[ECD_APF_OFF_BIT];
         ctrl.npf_enable <= !diag_reg[ECD_NPF_OFF_BIT];
         ctrl.rx_gain <= thr_gain_reg[ECD_RX_GAIN_LSB +: 2];
         ctrl.tx_gain <= thr_gain_reg[ECD_TX_GAIN_LSB +: 2];
         ctrl.acoustic_sidetone_level <= diag_reg[ECD_ACOUSTIC_SIDETONE_LEVEL_LSB +: 2];
         ctrl.network_sidetone_level <= diag_reg[ECD_NETWORK_SIDETONE_LEVEL_LSB +: 2];
      end
   end

   // ************************************************************
   // status and read channel
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_reg <= 8'h00;
      end else begin
         status_reg <= {aec_dcode == ECD_CODE_RSVD || aec_ncode == ECD_CODE_RSVD,
                        nec_dcode == ECD_CODE_RSVD || nec_ncode == ECD_CODE_RSVD,
                        aec_on, nec_on, aec_ok, nec_ok, duplex_state};
      end
   end

   // measurement snapshot for software, one cycle behind the engine
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         estim_reg <= 32'h0000_0000;
      end else begin
         estim_reg <= {aec_meas.erle_db, aec_meas.noise_db, nec_meas.erle_db, nec_meas.noise_db};
      end
   end

   // ************************************************************
   // read decode: unmapped offsets answer zero with an error
   // ************************************************************
   logic [31:0] rd_word;
   logic rd_err;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      case (s_axi_araddr)
         ECD_OFS_THR_GAIN: rd_word = {16'h0000, thr_gain_reg};
         ECD_OFS_DIAG: rd_word = {16'h0000, diag_reg};
         ECD_OFS_ESTIM: rd_word = estim_reg;
         ECD_OFS_STATUS: rd_word = {24'h000000, status_reg};
         ECD_OFS_ID: rd_word = {16'h0000, ECD_ID_VALUE};
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ECD_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_err ? ECD_RESP_SLVERR : ECD_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready;
      end
   end

endmodule

// >>> test/ecd_config_monitor.sv
/*
 * Checker for ecd_config: read-back agrees with ctrl, event responses.
 * Assumes ecd_pkg is compiled first; attached to ecd_config by bind.
 */
`timescale 1ns/100ps
module ecd_config_monitor
   import ecd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic howl_event,
   input wire logic tone_event,
   input wire ecd_ctrl_s ctrl,
   input wire ecd_duplex_e duplex_state
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_rd(logic [7:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence

   a_thr_tag: assert property (s_rd(ECD_OFS_THR_GAIN) |=> s_axi_rdata[3:0] == ECD_TAG_THR_GAIN)
      else $error("threshold word read without its tag");
   a_diag_tag: assert property (s_rd(ECD_OFS_DIAG) |=> s_axi_rdata[3:0] == ECD_TAG_DIAG)
      else $error("diagnostic word read without its tag");
   a_gain_match: assert property (s_rd(ECD_OFS_THR_GAIN) |=>
      s_axi_rdata[7:4] == {ctrl.rx_gain, ctrl.tx_gain})
      else $error("gain outputs differ from stored word");
   a_sdt_match: assert property (s_rd(ECD_OFS_DIAG) |=> s_axi_rdata[7:4] == {ctrl.acoustic_sidetone_level, ctrl.network_sidetone_level})
      else $error("sidetone outputs differ from stored word");
   a_enable_match: assert property (s_rd(ECD_OFS_DIAG) |=> s_axi_rdata[13:9] ==
      ~{ctrl.apc_enable, ctrl.npc_enable, ctrl.apf_enable, ctrl.npf_enable, ctrl.aec_in_path})
      else $error("enable outputs differ from disable bits");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ECD_OFS_ID |=>
      s_axi_rresp == ECD_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_clear_pair: assert property (ctrl.nec_clear |-> ctrl.aec_clear && duplex_state == ECD_DUP_HALF_IDLE)
      else $error("network clear without acoustic clear and half duplex");
   a_clear_cause: assert property (ctrl.aec_clear |-> $past(howl_event) || $past(tone_event))
      else $error("acoustic clear without an event");
   a_freeze_cause: assert property ($rose(ctrl.aec_freeze) |->
      $past(tone_event) && $past(duplex_state) == ECD_DUP_FULL)
      else $error("freeze without tone in full duplex");
endmodule

bind ecd_config ecd_config_monitor ecd_config_monitor_i (.clk_sys, .rst, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .howl_event, .tone_event, .ctrl, .duplex_state);

// >>> test/test_ecd_config.sv
/*
 * Self-checking bench for ecd_config over AXI4-Lite and event inputs.
 * Assumes ecd_pkg and the bound checker are compiled first.
 */
`timescale 1ns/100ps
module test_ecd_config
   import ecd_pkg::*;
;
   logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, howl, tone;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   wire logic awready, wready, bvalid, arready, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   ecd_canc_meas_s am, nm;
   ecd_ctrl_s ctrl;
   ecd_duplex_e dup;
   int err_total, n_checks, i;
   logic [1:0] g;
   logic [15:0] d;

   ecd_config #(.FREEZE_CYCLES(4)) ecd_config_i (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .aec_meas(am), .nec_meas(nm), .howl_event(howl), .tone_event(tone), .ctrl(ctrl), .duplex_state(dup));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, v);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {16'h0000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!(bvalid && bready));
      bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!(rvalid && rready));
      rready <= 1'h0;
      chk("rdata", {16'h0000, e}, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   task automatic wst(input ecd_duplex_e e);
      for (int k = 0; k < 20 && dup !== e; k++) @(negedge clk_sys);
      chk("duplex", {30'h0, e}, {30'h0, dup});
   endtask

   task automatic not_full;
      repeat (10) @(negedge clk_sys);
      chk("not_full", 32'h0, {31'h0, dup === ECD_DUP_FULL});
   endtask

   // one-cycle event: howl when h is 1, tone otherwise
   task automatic pulse(input logic h);
      @(posedge clk_sys);
      howl <= h;
      tone <= !h;
      @(posedge clk_sys);
      howl <= 1'h0;
      tone <= 1'h0;
      @(negedge clk_sys);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // clock, watchdog, tests
   // ************************************************************
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      report_and_stop;
   end

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, howl, tone} = 7'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      am = {8'h1E, 8'h00, 8'h00, 1'h1};
      nm = {8'h1E, 8'h00, 8'h00, 1'h1};
      rst = 1'h1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (2) @(negedge clk_sys);
      chk("in_path", 32'h3, {30'h0, ctrl.aec_in_path, ctrl.nec_in_path});
      chk("enables", 32'hF, {28'h0, ctrl.apc_enable, ctrl.npc_enable, ctrl.apf_enable, ctrl.npf_enable});
      chk("levels", 32'h0, {24'h0, ctrl.rx_gain, ctrl.tx_gain, ctrl.acoustic_sidetone_level, ctrl.network_sidetone_level});
      rd(ECD_OFS_THR_GAIN, 16'h0008, ECD_RESP_OKAY);
      rd(ECD_OFS_DIAG, 16'h000A, ECD_RESP_OKAY);
      wst(ECD_DUP_FULL);
      for (i = 0; i < 4; i++) begin
         g = i[1:0];
         wr(ECD_OFS_THR_GAIN, {8'h00, g, g, 4'h8}, ECD_RESP_OKAY);
         rd(ECD_OFS_THR_GAIN, {8'h00, g, g, 4'h8}, ECD_RESP_OKAY);
         chk("gain", {28'h0, g, g}, {28'h0, ctrl.rx_gain, ctrl.tx_gain});
         wr(ECD_OFS_DIAG, {8'h00, g, ~g, 4'hA}, ECD_RESP_OKAY);
         rd(ECD_OFS_DIAG, {8'h00, g, ~g, 4'hA}, ECD_RESP_OKAY);
         chk("sdt", {28'h0, g, ~g}, {28'h0, ctrl.acoustic_sidetone_level, ctrl.network_sidetone_level});
      end
      for (i = 8; i < 16; i++) begin
         d = 16'h000A | (16'h0001 << i);
         wr(ECD_OFS_DIAG, d, ECD_RESP_OKAY);
         rd(ECD_OFS_DIAG, d, ECD_RESP_OKAY);
         chk("disables", {27'h0, ~d[13:9]}, {27'h0, ctrl.apc_enable, ctrl.npc_enable,
            ctrl.apf_enable, ctrl.npf_enable, ctrl.aec_in_path});
         chk("nec_path", {31'h0, ~d[8]}, {31'h0, ctrl.nec_in_path});
      end
      pulse(1'h1);
      chk("howl_off", 32'h0, {30'h0, ctrl.aec_clear, ctrl.nec_clear});
      wr(ECD_OFS_DIAG, 16'h030A, ECD_RESP_OKAY);
      not_full;
      wr(ECD_OFS_DIAG, 16'h000A, ECD_RESP_OKAY);
      wst(ECD_DUP_FULL);
      pulse(1'h0);
      chk("freeze", 32'h3, {30'h0, ctrl.aec_freeze, dup === ECD_DUP_FULL});
      repeat (8) @(negedge clk_sys);
      chk("freeze_end", 32'h0, {31'h0, ctrl.aec_freeze});
      pulse(1'h1);
      chk("howl", 32'h3, {30'h0, ctrl.aec_clear, ctrl.nec_clear});
      chk("howl_dup", {30'h0, ECD_DUP_HALF_IDLE}, {30'h0, dup});
      @(posedge clk_sys);
      am <= {8'h0A, 8'h00, 8'h00, 1'h1};
      pulse(1'h0);
      chk("tone_half", 32'h2, {30'h0, ctrl.aec_clear, ctrl.nec_clear});
      chk("tone_dup", {30'h0, ECD_DUP_HALF_RX}, {30'h0, dup});
      wr(ECD_OFS_THR_GAIN, 16'h1008, ECD_RESP_OKAY);
      @(posedge clk_sys);
      am <= {8'h0A, 8'h14, 8'h28, 1'h1};
      not_full;
      @(posedge clk_sys);
      am <= {8'h0A, 8'h3C, 8'h28, 1'h1};
      wst(ECD_DUP_FULL);
      wr(ECD_OFS_THR_GAIN, 16'h0108, ECD_RESP_OKAY);
      @(posedge clk_sys);
      nm <= {8'h1E, 8'h00, 8'h00, 1'h0};
      repeat (3) @(negedge clk_sys);
      chk("nec_auto_off", 32'h0, {31'h0, ctrl.nec_in_path});
      @(posedge clk_sys);
      nm <= {8'h1E, 8'h00, 8'h00, 1'h1};
      repeat (3) @(negedge clk_sys);
      chk("nec_back_on", 32'h1, {31'h0, ctrl.nec_in_path});
      @(posedge clk_sys);
      am <= {8'h1E, 8'h00, 8'h00, 1'h1};
      nm <= {8'h0A, 8'h14, 8'h28, 1'h1};
      not_full;
      @(posedge clk_sys);
      nm <= {8'h0A, 8'h3C, 8'h28, 1'h1};
      wst(ECD_DUP_FULL);
      wr(ECD_OFS_THR_GAIN, 16'hF000, ECD_RESP_SLVERR);
      rd(ECD_OFS_THR_GAIN, 16'h0108, ECD_RESP_OKAY);
      wr(ECD_OFS_ESTIM, 16'h0008, ECD_RESP_SLVERR);
      rd(8'h14, 16'h0000, ECD_RESP_SLVERR);
      rd(ECD_OFS_ID, ECD_ID_VALUE, ECD_RESP_OKAY);
      report_and_stop;
   end
endmodule
